// file: core/cantc_defines.vh
`ifndef CANTC_DEFINES_VH
`define CANTC_DEFINES_VH
`define CANTC_ADDR_XMIT_CTL 16'hFFB1
`define CANTC_ADDR_TIMING_LO 16'hFFB9
`define CANTC_ADDR_TIMING_HI 16'hFFBA
`define CANTC_XMIT_CTL_RESET 8'h00
`define CANTC_TIMING_LO_RESET 8'h18
`define CANTC_TIMING_HI_RESET 8'h0E
`define CANTC_FLAGS_RESET 2'h0
`define CANTC_BIT_RESET 1'h0
`define CANTC_RESERVED_BIT 1'h0
`define CANTC_RECESSIVE 1'h1
`define CANTC_SAMPLE_IDLE 2'h3
`define CANTC_RDATA_RESET 8'h00
`define CANTC_QCLK_RESET 8'h00
`define CANTC_UPPER_PRESCALER_OFF 2'h0
`define CANTC_PRESCALER_LOW_MSB 5
`define CANTC_TIMING_FIELD_MSB 3
`define CANTC_BIT_RQ0 0
`define CANTC_BIT_RQ1 1
`define CANTC_BIT_AB0 2
`define CANTC_BIT_AB1 3
`define CANTC_BIT_CP0 4
`define CANTC_BIT_CP1 5
`define CANTC_BIT_PRIO 7
`define CANTC_BIT_LISTEN 4
`define CANTC_BIT_TRIPLE 5
`define CANTC_BIT_SOF_CLR 6
`define CANTC_BIT_QRES 7
`define CANTC_RX_MSG4 4'h4
`define CANTC_QUANTUM_CLKS 2
`endif

// file: core/cantc_transmit_control.v
// Functional notes
// - listen-only set: transmit line never driven; clear: normal operation.
// - listen-only mode sends no acknowledge, error frame or message.
// - listen-only mode freezes both error counters.
// - sampling select 0 samples once; 1 takes majority of three samples.
// - frame-start clear set and mode selected: message 4 reception clears flag enable.
// - resolution select 0: one quantum is two clocks, upper prescaler bits ignored.
// - both pending: priority bit picks buffer; single request ignores it.
// - transmit control resets to zero; bit 6 reads 0; completion flags read-only.
// - writing 1 requests transmission, 0 ignored; read shows buffer occupied.
// - request cleared only on error-free finish, completed abort or init request.
// - errored transmission keeps request set and retries.
// - request bits sampled just before frame start; set order irrelevant.
// - writing 1 requests abort, 0 ignored; read 1 means abort pending.
// - abort bit clears together with its request bit.
// - abort never cuts short a frame already on the bus.
// - completion cleared for abort before arbitration, abort with lost arbitration or error, or error after init request.
// - abort during a frame that then succeeds sets completion flag.
// - completion flags updated at end of each successful or aborted transmission and each errored one after init request; retried ones leave them.
// - init request clears request and abort bits; running frame not retried.
`timescale 1ns/1ps
`include "cantc_defines.vh"
module cantc_transmit_control (
	input wire clk,
	input wire rst_n,
	input wire [15:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	input wire init_request,
	input wire init_confirmed,
	input wire frame_start_ok,
	output reg frame_start,
	output reg frame_buffer,
	input wire arb_started,
	input wire arb_lost,
	input wire frame_done_ok,
	input wire frame_done_err,
	input wire bus_error,
	input wire ack_slot,
	input wire [3:0] rx_msg_index,
	input wire rx_msg_stored,
	input wire frame_start_source_sel,
	input wire sample_tick,
	input wire rx_line,
	input wire tx_bit,
	input wire tx_bit_en,
	input wire [7:0] quantum_prescaler,
	output reg tx_line,
	output reg rx_sampled,
	output reg frame_start_flag_clr,
	output reg err_count_en,
	output reg [7:0] quantum_clocks,
	output reg listen_only_sel,
	output reg triple_sample_sel,
	output reg quantum_resolution_sel
);
	localparam ST_IDLE = 3'h1;
	localparam ST_ARB = 3'h2;
	localparam ST_FRAME = 3'h4;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [1:0] tx_request;
	reg [1:0] tx_abort;
	reg [1:0] tx_complete;
	reg tx_priority_sel;
	reg [7:0] bit_timing_ctl_lo;
	reg frame_start_clear_ctl;
	reg [3:0] bit_timing_hi_low;
	reg cur_buf;
	reg no_retry;
	reg [1:0] triple_sample_sel_hist;
	reg [1:0] next_request;
	reg [1:0] next_abort;
	reg [1:0] next_complete;
	reg pick;
	wire [7:0] xmit_ctl_value;
	wire [7:0] timing_hi_value;
	wire xmit_ctl_sel;
	wire timing_lo_sel;
	wire timing_hi_sel;
	wire xmit_ctl_wr;
	wire timing_wr_ok;
	wire timing_lo_wr;
	wire timing_hi_wr;
	wire [1:0] wr_request;
	wire [1:0] wr_abort;
	wire done_any;
	wire start_now;
	wire majority;
	wire listen_block;
	wire sof_hit;

	// register address decode
	assign xmit_ctl_sel = (sfr_addr == `CANTC_ADDR_XMIT_CTL);
	assign timing_lo_sel = (sfr_addr == `CANTC_ADDR_TIMING_LO);
	assign timing_hi_sel = (sfr_addr == `CANTC_ADDR_TIMING_HI);

	// read images
	assign xmit_ctl_value = {tx_priority_sel, `CANTC_RESERVED_BIT, tx_complete, tx_abort, tx_request};
	assign timing_hi_value = {quantum_resolution_sel, frame_start_clear_ctl, triple_sample_sel,
		listen_only_sel, bit_timing_hi_low};

	// write strobes; init mode blocks transmit control writes
	assign xmit_ctl_wr = sfr_wr && xmit_ctl_sel && !init_request;
	assign timing_wr_ok = sfr_wr && init_request && init_confirmed;
	assign timing_lo_wr = timing_wr_ok && timing_lo_sel;
	assign timing_hi_wr = timing_wr_ok && timing_hi_sel;
	assign wr_request = sfr_wdata[`CANTC_BIT_RQ1:`CANTC_BIT_RQ0];
	assign wr_abort = sfr_wdata[`CANTC_BIT_AB1:`CANTC_BIT_AB0];

	// frame events
	assign done_any = frame_done_ok || frame_done_err || arb_lost;
	assign start_now = (state == ST_IDLE) && (next_state == ST_ARB);

	// transmit line gate
	assign listen_block = listen_only_sel || !tx_bit_en;

	// frame-start flag clear cause
	assign sof_hit = frame_start_clear_ctl && frame_start_source_sel && rx_msg_stored &&
		(rx_msg_index == `CANTC_RX_MSG4);

	// vote over two stored samples and the current one
	assign majority = (triple_sample_sel_hist[0] & triple_sample_sel_hist[1]) | (triple_sample_sel_hist[0] & rx_line) |
		(triple_sample_sel_hist[1] & rx_line);

	// buffer choice
	always @* begin
		if (tx_request[0] && tx_request[1])
			pick = tx_priority_sel;
		else
			pick = tx_request[1];
	end

	// next flags and state
	always @* begin
		next_state = state;
		next_request = tx_request;
		next_abort = tx_abort;
		next_complete = tx_complete;
		case (state)
			ST_IDLE: begin
				if (tx_abort[0] && tx_request[0]) begin
					next_request[0] = 1'b0;
					next_abort[0] = 1'b0;
					next_complete[0] = 1'b0;
				end
				if (tx_abort[1] && tx_request[1]) begin
					next_request[1] = 1'b0;
					next_abort[1] = 1'b0;
					next_complete[1] = 1'b0;
				end
				if (frame_start_ok && !listen_only_sel && !init_request && (tx_request != `CANTC_FLAGS_RESET) &&
					!(tx_abort[pick]))
					next_state = ST_ARB;
			end
			ST_ARB: begin
				if (arb_lost || frame_done_err)
					next_state = ST_IDLE;
				else if (arb_started)
					next_state = ST_FRAME;
			end
			ST_FRAME: begin
				if (frame_done_ok || frame_done_err)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		if ((state != ST_IDLE) && done_any) begin
			if (frame_done_ok) begin
				next_request[cur_buf] = 1'b0;
				next_abort[cur_buf] = 1'b0;
				next_complete[cur_buf] = 1'b1;
			end else if (tx_abort[cur_buf]) begin
				next_request[cur_buf] = 1'b0;
				next_abort[cur_buf] = 1'b0;
				next_complete[cur_buf] = 1'b0;
			end else if (no_retry && frame_done_err) begin
				next_complete[cur_buf] = 1'b0;
			end
			// otherwise request stays set for retry
		end
		// software set applied after the frame-end clears so a new request wins over a clear
		if (xmit_ctl_wr) begin
			next_abort = next_abort | (wr_abort & (next_request | wr_request));
			next_request = next_request | wr_request;
		end
		if (init_request) begin
			next_request = `CANTC_FLAGS_RESET;
			next_abort = `CANTC_FLAGS_RESET;
		end
	end

	// transfer state
	always @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// request, abort and completion flags
	always @(posedge clk) begin
		if (!rst_n) begin
			tx_request <= `CANTC_FLAGS_RESET;
			tx_abort <= `CANTC_FLAGS_RESET;
			tx_complete <= `CANTC_FLAGS_RESET;
		end else begin
			tx_request <= next_request;
			tx_abort <= next_abort;
			tx_complete <= next_complete;
		end
	end

	// priority bit
	always @(posedge clk) begin
		if (!rst_n) begin
			tx_priority_sel <= `CANTC_BIT_RESET;
		end else if (xmit_ctl_wr) begin
			tx_priority_sel <= sfr_wdata[`CANTC_BIT_PRIO];
		end
	end

	// low bit-timing register
	always @(posedge clk) begin
		if (!rst_n) begin
			bit_timing_ctl_lo <= `CANTC_TIMING_LO_RESET;
		end else if (timing_lo_wr) begin
			bit_timing_ctl_lo <= sfr_wdata;
		end
	end

	// high bit-timing register
	always @(posedge clk) begin
		if (!rst_n) begin
			{quantum_resolution_sel, frame_start_clear_ctl, triple_sample_sel, listen_only_sel,
				bit_timing_hi_low} <= `CANTC_TIMING_HI_RESET;
		end else if (timing_hi_wr) begin
			quantum_resolution_sel <= sfr_wdata[`CANTC_BIT_QRES];
			frame_start_clear_ctl <= sfr_wdata[`CANTC_BIT_SOF_CLR];
			triple_sample_sel <= sfr_wdata[`CANTC_BIT_TRIPLE];
			listen_only_sel <= sfr_wdata[`CANTC_BIT_LISTEN];
			bit_timing_hi_low <= sfr_wdata[`CANTC_TIMING_FIELD_MSB:0];
		end
	end

	// frame start pulse and buffer index
	always @(posedge clk) begin
		if (!rst_n) begin
			cur_buf <= `CANTC_BIT_RESET;
			frame_start <= `CANTC_BIT_RESET;
			frame_buffer <= `CANTC_BIT_RESET;
		end else begin
			frame_start <= start_now;
			if (start_now)
				cur_buf <= pick;
			frame_buffer <= start_now ? pick : cur_buf;
		end
	end

	// no retry after init request during a frame
	always @(posedge clk) begin
		if (!rst_n) begin
			no_retry <= `CANTC_BIT_RESET;
		end else if (state == ST_IDLE) begin
			no_retry <= `CANTC_BIT_RESET;
		end else if (init_request) begin
			no_retry <= 1'h1;
		end
	end

	// register reads
	always @(posedge clk) begin
		if (!rst_n) begin
			sfr_rdata <= `CANTC_RDATA_RESET;
		end else if (sfr_rd) begin
			case (sfr_addr)
				`CANTC_ADDR_XMIT_CTL: sfr_rdata <= xmit_ctl_value;
				`CANTC_ADDR_TIMING_LO: sfr_rdata <= bit_timing_ctl_lo;
				`CANTC_ADDR_TIMING_HI: sfr_rdata <= timing_hi_value;
				default: sfr_rdata <= `CANTC_RDATA_RESET;
			endcase
		end
	end

	// sample history
	always @(posedge clk) begin
		if (!rst_n) begin
			triple_sample_sel_hist <= `CANTC_SAMPLE_IDLE;
		end else if (sample_tick) begin
			triple_sample_sel_hist <= {triple_sample_sel_hist[0], rx_line};
		end
	end

	// sampled receive level
	always @(posedge clk) begin
		if (!rst_n) begin
			rx_sampled <= `CANTC_RECESSIVE;
		end else if (sample_tick) begin
			rx_sampled <= triple_sample_sel ? majority : rx_line;
		end
	end

	// transmit line
	always @(posedge clk) begin
		if (!rst_n) begin
			tx_line <= `CANTC_RECESSIVE;
		end else begin
			tx_line <= listen_block ? `CANTC_RECESSIVE : tx_bit;
		end
	end

	// error counter enable
	always @(posedge clk) begin
		if (!rst_n) begin
			err_count_en <= `CANTC_BIT_RESET;
		end else begin
			err_count_en <= bus_error && !listen_only_sel;
		end
	end

	// frame-start flag clear pulse
	always @(posedge clk) begin
		if (!rst_n) begin
			frame_start_flag_clr <= `CANTC_BIT_RESET;
		end else begin
			frame_start_flag_clr <= sof_hit;
		end
	end

	// quantum prescaler as used
	always @(posedge clk) begin
		if (!rst_n) begin
			quantum_clocks <= `CANTC_QCLK_RESET;
		end else if (quantum_resolution_sel) begin
			quantum_clocks <= quantum_prescaler;
		end else begin
			quantum_clocks <= {`CANTC_UPPER_PRESCALER_OFF, quantum_prescaler[`CANTC_PRESCALER_LOW_MSB:0]};
		end
	end
endmodule

// file: test/cantc_chk.sv
`timescale 1ns/1ps
module cantc_chk (
	input wire clk, rst_n, sfr_rd, frame_start, bus_error, err_count_en, sample_tick, rx_line, rx_sampled,
	input wire tx_bit, tx_bit_en, tx_line, rx_msg_stored, frame_start_source_sel, frame_start_flag_clr,
	input wire listen_only_sel, triple_sample_sel, quantum_resolution_sel,
	input wire [15:0] sfr_addr,
	input wire [7:0] sfr_rdata, quantum_clocks,
	input wire [3:0] rx_msg_index
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_tx_quiet: assert property ($past(listen_only_sel) |-> tx_line)
		else $error("tx line driven while listening");
	chk_tx_follows: assert property ($past(rst_n && tx_bit_en && !listen_only_sel) |-> tx_line == $past(tx_bit))
		else $error("tx line not following tx bit");
	chk_count_frozen: assert property ($past(listen_only_sel) |-> !err_count_en)
		else $error("error count enabled while listening");
	chk_error_counted: assert property ($past(rst_n && bus_error && !listen_only_sel) |-> err_count_en)
		else $error("bus error not counted");
	chk_single_sample: assert property ($past(rst_n && sample_tick && !triple_sample_sel) |->
		rx_sampled == $past(rx_line))
		else $error("single sample mismatch");
	chk_sof_cause: assert property (frame_start_flag_clr |->
		$past(rx_msg_stored && rx_msg_index == 4'h4 && frame_start_source_sel))
		else $error("frame start flag cleared without cause");
	chk_quantum_upper: assert property (!quantum_resolution_sel && $past(!quantum_resolution_sel) |->
		quantum_clocks[7:6] == 2'h0)
		else $error("upper prescaler bits used");
	chk_bit6_zero: assert property (sfr_rd && sfr_addr == 16'hFFB1 |=> !sfr_rdata[6])
		else $error("transmit control bit 6 set");
	chk_start_pulse: assert property (frame_start |=> !frame_start)
		else $error("frame start longer than one cycle");
endmodule
bind cantc_transmit_control cantc_chk i_cantc_chk (.*);

// file: test/cantc_bus_node.sv
`timescale 1ns/1ps
module cantc_bus_node (
	input wire clk,
	input wire frame_start,
	input wire [1:0] mode,
	output reg arb_started = 1'h0,
	output reg arb_lost = 1'h0,
	output reg frame_done_ok = 1'h0,
	output reg frame_done_err = 1'h0
);
	reg [2:0] t = 3'h0;
	// mode 0 ends well, 1 ends in error, 2 loses arbitration
	always @(negedge clk) begin
		arb_started <= t == 3'h1 && mode != 2'h2;
		arb_lost <= t == 3'h1 && mode == 2'h2;
		frame_done_ok <= t == 3'h6 && mode == 2'h0;
		frame_done_err <= t == 3'h6 && mode == 2'h1;
		if (frame_start) t <= 3'h1;
		else if (t == 3'h6 || (t == 3'h1 && mode == 2'h2)) t <= 3'h0;
		else if (t != 3'h0) t <= t + 3'h1;
	end
endmodule

// file: test/cantc_transmit_control_tb_top.sv
`timescale 1ns/1ps
module cantc_transmit_control_tb_top;
	reg clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, init_request = 0, init_confirmed = 0, frame_start_ok = 0;
	reg bus_error = 0, rx_msg_stored = 0, frame_start_source_sel = 0, sample_tick = 0, rx_line = 0;
	reg tx_bit = 0, tx_bit_en = 1;
	reg [15:0] sfr_addr = 0;
	reg [7:0] sfr_wdata = 0, quantum_prescaler = 8'hFF;
	reg [3:0] rx_msg_index = 0;
	reg [1:0] mode = 0;
	wire ack_slot = 1'h0;
	wire [7:0] sfr_rdata, quantum_clocks;
	wire frame_start, frame_buffer, arb_started, arb_lost, frame_done_ok, frame_done_err, tx_line, rx_sampled;
	wire frame_start_flag_clr, err_count_en, listen_only_sel, triple_sample_sel, quantum_resolution_sel;
	integer n_mismatch = 0, n_tests = 0, i;
	cantc_transmit_control i_cantc_transmit_control (.*);
	cantc_bus_node i_cantc_bus_node (.*);
	initial forever #50 clk = ~clk;
	task chk(input [31:0] n, input [7:0] v, input [7:0] e);
		n_tests = n_tests + 1;
		if (v !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value %s: expected %h seen %h", n, e, v);
		end
	endtask
	task wr(input [15:0] a, input [7:0] d);
		@(negedge clk) begin
			sfr_addr = a;
			sfr_wdata = d;
			sfr_wr = 1;
		end
		@(negedge clk) sfr_wr = 0;
	endtask
	task ck(input [15:0] a, input [7:0] e);
		@(negedge clk) begin
			sfr_addr = a;
			sfr_rd = 1;
		end
		@(negedge clk) sfr_rd = 0;
		chk("reg", sfr_rdata, e);
	endtask
	task wfs(input e);
		integer k;
		k = 0;
		while (frame_start !== 1'h1 && k < 40) begin
			@(negedge clk);
			k = k + 1;
		end
		chk("fbuf", {6'h0, frame_start, frame_buffer}, {6'h0, 1'h1, e});
		@(negedge clk);
	endtask
	task wrap_up;
		if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		n_mismatch = n_mismatch + 1;
		wrap_up;
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1;
		ck(16'hFFB1, 8'h00);
		ck(16'hFFB9, 8'h18);
		ck(16'hFFBA, 8'h0E);
		ck(16'hFFB0, 8'h00);
		wr(16'hFFB1, 8'hC3);
		ck(16'hFFB1, 8'h83);
		wr(16'hFFB1, 8'h30);
		ck(16'hFFB1, 8'h03);
		wr(16'hFFB1, 8'h80);
		frame_start_ok = 1;
		wfs(1);
		wfs(0);
		repeat (9) @(negedge clk);
		ck(16'hFFB1, 8'hB0);
		mode = 1;
		wr(16'hFFB1, 8'h01);
		wfs(0);
		wfs(0);
		mode = 0;
		repeat (9) @(negedge clk);
		ck(16'hFFB1, 8'h30);
		frame_start_ok = 0;
		wr(16'hFFB1, 8'h01);
		wr(16'hFFB1, 8'h05);
		ck(16'hFFB1, 8'h20);
		frame_start_ok = 1;
		for (i = 0; i < 2; i = i + 1) begin
			mode = i[1:0];
			wr(16'hFFB1, 8'h01);
			wfs(0);
			wr(16'hFFB1, 8'h04);
			ck(16'hFFB1, i ? 8'h35 : 8'h25);
			repeat (9) @(negedge clk);
			ck(16'hFFB1, i ? 8'h20 : 8'h30);
		end
		frame_start_ok = 0;
		wr(16'hFFB1, 8'h03);
		init_request = 1;
		ck(16'hFFB1, 8'h20);
		wr(16'hFFBA, 8'h10);
		ck(16'hFFBA, 8'h0E);
		init_confirmed = 1;
		for (i = 0; i < 2; i = i + 1) begin
			wr(16'hFFBA, i ? 8'h20 : 8'h10);
			bus_error = 1;
			sample_tick = 1;
			rx_line = !rx_line;
			@(negedge clk) bus_error = 0;
			sample_tick = 0;
			chk("err", {7'h0, err_count_en}, {7'h0, i[0]});
			chk("txl", {7'h0, tx_line}, {7'h0, !i[0]});
		end
		wr(16'hFFBA, 8'h40);
		frame_start_source_sel = 1;
		for (i = 3; i < 5; i = i + 1) begin
			rx_msg_index = i[3:0];
			rx_msg_stored = 1;
			@(negedge clk) rx_msg_stored = 0;
			chk("sof", {7'h0, frame_start_flag_clr}, {7'h0, i == 4});
		end
		wrap_up;
	end
endmodule
